// file: src/sds_pkg.sv
package sds_pkg;
  // System clock rate in hertz.
  localparam int unsigned CLK_HZ = 10_000_000;
  // Supported line rates in baud.
  localparam int unsigned BAUD_LO = 9600;
  localparam int unsigned BAUD_HI = 76800;
  localparam int unsigned BAUD_300 = 300;
  localparam int unsigned BAUD_1200 = 1200;
  // Clock cycles per bit, rounded down.
  localparam logic [15:0] DIV_LO = 16'(CLK_HZ / BAUD_LO);
  localparam logic [15:0] DIV_HI = 16'(CLK_HZ / BAUD_HI);
  localparam logic [15:0] DIV_300 = 16'(CLK_HZ / BAUD_300);
  localparam logic [15:0] DIV_1200 = 16'(CLK_HZ / BAUD_1200);
  // Baud select codes.
  localparam logic [1:0] BSEL_9600 = 2'h0;
  localparam logic [1:0] BSEL_76800 = 2'h1;
  localparam logic [1:0] BSEL_300 = 2'h2;
  localparam logic [1:0] BSEL_1200 = 2'h3;
  // Storage geometry: 256 words, bit 8 tags a file separator.
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PTR_W = 8;
  localparam logic [PTR_W-1:0] PTR_LAST = 8'hFF;
  // Module address range and reset value.
  localparam logic [3:0] ADDR_MIN = 4'h1;
  localparam logic [3:0] ADDR_MAX = 4'h8;
  localparam logic [3:0] ADDR_RST = 4'h1;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RIDX = 8'h0C;
  localparam logic [7:0] OFS_RDAT = 8'h10;
  // Control register fields.
  localparam int unsigned CTRL_METHOD = 0;
  localparam int unsigned CTRL_FILL = 1;
  localparam int unsigned CTRL_BAUD = 2;
  localparam int unsigned CTRL_MARK = 4;
  localparam int unsigned CTRL_WAKE = 5;
  localparam int unsigned CTRL_DUMP = 6;
  // Status register fields.
  localparam int unsigned STAT_FULL = 8;
  localparam int unsigned STAT_STBY = 9;
  localparam int unsigned STAT_LMARK = 10;
  localparam int unsigned STAT_ARMED = 11;
  localparam int unsigned STAT_ERR = 16;
  // Operating methods.
  typedef enum logic [1:0] {
    SDS_GATED = 2'b01,
    SDS_ADDRESSED = 2'b10
  } sds_method_e;
  // Receiver states.
  typedef enum logic [3:0] {
    SDS_RX_IDLE = 4'b0001,
    SDS_RX_START = 4'b0010,
    SDS_RX_DATA = 4'b0100,
    SDS_RX_STOP = 4'b1000
  } sds_rx_e;
endpackage

// file: src/sds_core.sv
// How it works
// R1 - Host connection writes separator at write pointer.
// R2 - Host tests presence before sending anything.
// R3 - Host sends backlog at 9600 once present.
// R4 - Host withholds transfer during other sessions.
// R5 - Host recompile skips untransferred records.
// R6 - Module address configurable from one to eight.
// R7 - Address resets to one.
// R8 - Address one served by lowest present module.
// R9 - Other addresses served only by exact match.
// R10 - Host never attaches duplicate addresses.
// R11 - Lowest fill-and-stop module fills first.
// R12 - Host waits per byte before readdressing.
// R13 - Host sends backlog to next named address.
// R14 - Burst capture at 76800 baud.
// R15 - Burst overflows into next lowest module.
// R16 - Gated method stores only while gate high.
// R17 - Power-up enters gated method.
// R18 - Gate high at power-up waits re-rise.
// R19 - Power loss drops data since gate rise.
// R20 - No module-to-module copy in gated method.
// R21 - Fill-and-stop refuses data when full.
// R22 - Ring mode overwrites oldest when full.
// R23 - No two consecutive file separators.
// R24 - Baud mismatch counts error, enters standby.
// R25 - Separator tagged apart from data bytes.
// R26 - Write pointer steps once, wraps or stops.
module sds_core
  import sds_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Host link.
  input  wire logic        serial_input_line,
  input  wire logic        capture_gate_line,
  input  wire logic        host_attached,
  input  wire logic        power_fail,
  input  wire logic        xfer_active,
  input  wire logic [3:0]  xfer_addr,
  input  wire logic        cmd_stb,
  input  wire logic [3:0]  cmd_addr,
  // Neighbour chain on the shared link.
  input  wire logic        lower_present,
  input  wire logic        lower_accepting,
  // Status toward host and peers.
  output logic             present_o,
  output logic             accepting_o,
  output logic             cmd_exec_o,
  output logic             dump_req_o
);

  // Reset release synchroniser and its local copy.
  logic             rst_s1_q;
  logic             rst_sync_n;
  // Register state.
  sds_method_e      method_q;
  logic             fill_q;
  logic [1:0]       baud_q;
  logic [3:0]       addr_q;
  logic [PTR_W-1:0] ridx_q;
  // Storage state.
  logic [8:0]       mem [MEM_DEPTH];
  logic [PTR_W-1:0] wptr_q;
  logic [PTR_W-1:0] gate_start_q;
  logic             full_q;
  logic             lmark_q;
  logic             mark_pend_q;
  // Gate and link edge tracking.
  logic             gate_q;
  logic             armed_q;
  logic             att_q;
  logic             pf_q;
  // Error counter and standby.
  logic [7:0]       err_q;
  logic             stby_q;
  // Receiver.
  sds_rx_e          rx_q;
  logic [15:0]      bcnt_q;
  logic [2:0]       bit_q;
  logic [7:0]       shf_q;
  logic             rx_vld;
  logic             rx_ferr;
  // Decode helpers.
  logic             bus_req;
  logic             bus_wr;
  logic             xfer_sel;
  logic             can_store;
  logic             take_byte;
  logic             take_mark;

  // Cycles per bit for a baud select code.
  function automatic logic [15:0] div_of(input logic [1:0] sel);
    logic [15:0] d;
    d = DIV_LO;
    if (sel == BSEL_76800)
    begin
      d = DIV_HI;
    end
    else if (sel == BSEL_300)
    begin
      d = DIV_300;
    end
    else if (sel == BSEL_1200)
    begin
      d = DIV_1200;
    end
    return d;
  endfunction

  // Whether this module answers a given link address.
  function automatic logic addr_hit(input logic [3:0] a,
                                    input logic [3:0] mine,
                                    input logic       low_here);
    logic h;
    h = 1'b0;
    if (a == ADDR_MIN)
    begin
      // Address one is served by its holder and also by the lowest module.
      h = (mine == ADDR_MIN) || !low_here; // R8
    end
    else
    begin
      h = (a == mine); // R9
    end
    return h;
  endfunction

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  // Address one traffic passes over us while any lower module accepts,
  // so a full lower module hands the stream on instead of stalling it.
  assign xfer_sel = (xfer_addr == ADDR_MIN) ? !lower_accepting // R11 R15
                                            : addr_hit(xfer_addr, addr_q,
                                                       lower_present); // R9
  // Full fill-and-stop memory takes nothing more.
  assign can_store = !(fill_q && full_q) && !stby_q; // R21
  assign take_byte = rx_vld && can_store
                     && ((method_q == SDS_GATED) ? (gate_q && armed_q) // R16
                                                 : (xfer_active && xfer_sel));
  // A separator waits for a free write slot.
  assign take_mark = mark_pend_q && !rx_vld && can_store;

  // One-cycle ack on every request; unmapped reads return zero.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0;
      if (bus_req && !wb_we_i)
      begin
        if (wb_adr_i == OFS_CTRL)
        begin
          wb_dat_o <= {25'h0, dump_req_o, 1'b0, 1'b0, baud_q, fill_q,
                       (method_q == SDS_ADDRESSED)};
        end
        else if (wb_adr_i == OFS_ADDR)
        begin
          wb_dat_o <= {28'h0, addr_q};
        end
        else if (wb_adr_i == OFS_STAT)
        begin
          wb_dat_o <= {8'h0, err_q, 4'h0, armed_q, lmark_q, stby_q,
                       full_q, wptr_q};
        end
        else if (wb_adr_i == OFS_RIDX)
        begin
          wb_dat_o <= {24'h0, ridx_q};
        end
        else if (wb_adr_i == OFS_RDAT)
        begin
          // Bit 8 marks a separator so it never reads as data.
          wb_dat_o <= {23'h0, mem[ridx_q]}; // R25
        end
      end
    end
  end

  // Configuration registers; method starts gated at every power-up.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      method_q <= SDS_GATED; // R17
      fill_q <= 1'b0; // R22
      baud_q <= BSEL_9600;
      addr_q <= ADDR_RST; // R7
      ridx_q <= '0;
    end
    else if (bus_wr)
    begin
      if (wb_adr_i == OFS_CTRL)
      begin
        method_q <= wb_dat_i[CTRL_METHOD] ? SDS_ADDRESSED : SDS_GATED;
        fill_q <= wb_dat_i[CTRL_FILL];
        baud_q <= wb_dat_i[CTRL_BAUD +: 2];
      end
      else if (wb_adr_i == OFS_ADDR)
      begin
        // Out-of-range addresses are ignored.
        if (wb_dat_i[3:0] >= ADDR_MIN && wb_dat_i[3:0] <= ADDR_MAX)
        begin
          addr_q <= wb_dat_i[3:0]; // R6
        end
      end
      else if (wb_adr_i == OFS_RIDX)
      begin
        ridx_q <= wb_dat_i[PTR_W-1:0];
      end
    end
  end

  // Peer dump request clears one cycle after the gated method is entered.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dump_req_o <= 1'b0;
    end
    else if (method_q == SDS_GATED)
    begin
      dump_req_o <= 1'b0; // R20
    end
    else if (bus_wr && wb_adr_i == OFS_CTRL)
    begin
      dump_req_o <= wb_dat_i[CTRL_DUMP];
    end
  end

  // Edge trackers for gate, attachment and power failure.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gate_q <= 1'b0;
      att_q <= 1'b0;
      pf_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      gate_q <= capture_gate_line;
      att_q <= host_attached;
      pf_q <= power_fail;
      // Arming needs the gate seen low once, so a high gate at
      // power-up is ignored until it falls and rises again.
      if (!capture_gate_line)
      begin
        armed_q <= 1'b1; // R18
      end
    end
  end

  // Separator request: set by attach or software, set beats clear.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mark_pend_q <= 1'b0;
    end
    else if ((host_attached && !att_q)
             || (bus_wr && wb_adr_i == OFS_CTRL && wb_dat_i[CTRL_MARK]))
    begin
      mark_pend_q <= 1'b1; // R1
    end
    else if (take_mark || (mark_pend_q && lmark_q))
    begin
      mark_pend_q <= 1'b0;
    end
  end

  // Storage writes; data wins the slot, a pending separator waits.
  always_ff @(posedge clk)
  begin
    if (take_byte)
    begin
      mem[wptr_q] <= {1'b0, shf_q};
    end
    else if (take_mark && !lmark_q)
    begin
      mem[wptr_q] <= 9'h100; // R1 R25
    end
  end

  // Write pointer, full flag, last-item kind and gate rollback point.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wptr_q <= '0;
      full_q <= 1'b0;
      lmark_q <= 1'b0;
      gate_start_q <= '0;
    end
    else if (power_fail && !pf_q && method_q == SDS_GATED && gate_q)
    begin
      // Partial gated block is discarded, not retained.
      wptr_q <= gate_start_q; // R19
    end
    else
    begin
      if (capture_gate_line && !gate_q)
      begin
        gate_start_q <= wptr_q;
      end
      if (take_byte || (take_mark && !lmark_q)) // R23
      begin
        lmark_q <= !take_byte;
        wptr_q <= wptr_q + 1'b1; // R26
        if (wptr_q == PTR_LAST)
        begin
          full_q <= 1'b1; // R22
        end
      end
    end
  end

  // Errors bump the counter and park the module until woken.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      err_q <= 8'h0;
      stby_q <= 1'b0;
    end
    else if (rx_ferr)
    begin
      err_q <= err_q + 1'b1; // R24
      stby_q <= 1'b1; // R24
    end
    else if (bus_wr && wb_adr_i == OFS_CTRL && wb_dat_i[CTRL_WAKE])
    begin
      stby_q <= 1'b0;
    end
  end

  // Serial receiver, 8N1; a low stop bit is taken as rate mismatch.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_q <= SDS_RX_IDLE;
      bcnt_q <= 16'h0;
      bit_q <= 3'h0;
      shf_q <= 8'h0;
      rx_vld <= 1'b0;
      rx_ferr <= 1'b0;
    end
    else
    begin
      rx_vld <= 1'b0;
      rx_ferr <= 1'b0;
      case (rx_q)
        SDS_RX_IDLE:
        begin
          // Standby ignores the line entirely to save power.
          if (!serial_input_line && !stby_q)
          begin
            rx_q <= SDS_RX_START;
            bcnt_q <= div_of(baud_q) >> 1; // R14
          end
        end
        SDS_RX_START:
        begin
          if (bcnt_q != 16'h0)
          begin
            bcnt_q <= bcnt_q - 1'b1;
          end
          else if (serial_input_line)
          begin
            // Glitch, not a start bit.
            rx_q <= SDS_RX_IDLE;
          end
          else
          begin
            rx_q <= SDS_RX_DATA;
            // Count to zero plus the sampling edge makes one bit time.
            bcnt_q <= div_of(baud_q) - 16'h1;
            bit_q <= 3'h0;
          end
        end
        SDS_RX_DATA:
        begin
          if (bcnt_q != 16'h0)
          begin
            bcnt_q <= bcnt_q - 1'b1;
          end
          else
          begin
            shf_q <= {serial_input_line, shf_q[7:1]};
            bcnt_q <= div_of(baud_q) - 16'h1;
            bit_q <= bit_q + 1'b1;
            if (bit_q == 3'h7)
            begin
              rx_q <= SDS_RX_STOP;
            end
          end
        end
        SDS_RX_STOP:
        begin
          if (bcnt_q != 16'h0)
          begin
            bcnt_q <= bcnt_q - 1'b1;
          end
          else
          begin
            rx_q <= SDS_RX_IDLE;
            rx_vld <= serial_input_line;
            rx_ferr <= !serial_input_line; // R24
          end
        end
        default:
        begin
          rx_q <= SDS_RX_IDLE;
        end
      endcase
    end
  end

  // Link status: presence lets the host gate its sends.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      present_o <= 1'b0;
      accepting_o <= 1'b0;
      cmd_exec_o <= 1'b0;
    end
    else
    begin
      present_o <= 1'b1; // R2
      accepting_o <= can_store; // R11 R15
      cmd_exec_o <= cmd_stb && addr_hit(cmd_addr, addr_q,
                                        lower_present); // R8 R9
    end
  end

endmodule

// file: verif/sds_core_properties.sv
module sds_core_properties
  import sds_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Commands and status.
  input wire logic        cmd_stb,
  input wire logic [3:0]  cmd_addr,
  input wire logic        lower_accepting,
  input wire logic        present_o,
  input wire logic        accepting_o,
  input wire logic        cmd_exec_o,
  input wire logic        dump_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic addr_q; // Shadow of the method bit.

  // Follows control writes, so gated operation is known here.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_q <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL)
      addr_q <= wb_dat_i[CTRL_METHOD];
  end

  // A pending request, then a single-cycle answer.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_one_pulse: assert property (s_req |=> s_ack)
    else $error("bus answer is not one pulse");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
    else $error("bus answer without request");
  a_present_up: assert property ($rose(rst_n) |-> ##[1:3] present_o)
    else $error("presence late after reset");
  a_present_holds: assert property (present_o |=> present_o)
    else $error("presence dropped");
  a_accept_reset: assert property ($rose(rst_n) |-> ##[1:3] accepting_o)
    else $error("not accepting after reset");
  a_exec_no_stb: assert property (!cmd_stb |=> !cmd_exec_o)
    else $error("command executed without strobe");
  a_exec_range: assert property (cmd_stb && (cmd_addr == 4'h0 ||
    cmd_addr > ADDR_MAX) |=> !cmd_exec_o)
    else $error("command outside address range executed");
  a_exec_lower: assert property (cmd_stb && cmd_addr == ADDR_MIN &&
    lower_accepting |=> !cmd_exec_o)
    else $error("address one taken from lower module");
  a_no_dump_gated: assert property (!addr_q ##1 !addr_q |-> !dump_req_o)
    else $error("peer dump in gated method");
endmodule

// file: verif/sds_host_model.sv
module sds_host_model
  import sds_pkg::*;
(
  // Clock and module presence.
  input wire logic clk,
  input wire logic present,
  // Serial line toward the module, idle high.
  output logic     serial_input_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line rests at its idle level between frames.
  initial serial_input_line = 1'b1;

  // Sends one 8N1 frame LSB first; bad gives a low stop bit.
  task automatic send(input logic [7:0] b, input logic [15:0] div,
                      input logic bad);
    logic [9:0] f;
    f = {~bad, b, 1'b0};
    if (!present)
      return;
    for (int i = 0; i < 10; i++)
    begin
      serial_input_line <= f[i];
      repeat (div) @(posedge clk);
    end
    // Idle gap lets the module finish storing the byte.
    serial_input_line <= 1'b1;
    repeat (div) @(posedge clk);
  endtask

  // Quiet time owed before a frame to another module address.
  task automatic readdress_gap(input int nbytes);
    repeat ((nbytes + 5) * (CLK_HZ / 1000)) @(posedge clk);
  endtask
endmodule

// file: verif/sds_core_tb.sv
module sds_core_tb
  import sds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [31:0] wd, rd;
  logic        gate, att, pf, cs, lp, la, xa; // Link-side inputs.
  logic [3:0]  ca, xad;
  logic        pres, acc, exec, dump, txd;
  logic [31:0] eq[$], mq[$]; // Expected read words and masks.
  logic        cq[$];        // Expected command outcomes.
  logic        cs_q = 1'b0;
  logic [7:0]  b, b2;
  logic [31:0] lfsr = 32'hBA20;
  int          fail_count = 0, checked = 0, cycles = 0;

  sds_core DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .serial_input_line(txd),
    .capture_gate_line(gate), .host_attached(att), .power_fail(pf),
    .xfer_active(xa), .xfer_addr(xad), .cmd_stb(cs), .cmd_addr(ca),
    .lower_present(lp), .lower_accepting(la), .present_o(pres),
    .accepting_o(acc), .cmd_exec_o(exec), .dump_req_o(dump));
  sds_host_model host (.clk(clk), .present(pres), .serial_input_line(txd));

  // Free-running clock, 100 ns period.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Shift register gives repeatable random bytes.
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One classic cycle; a read notes its expected word first.
  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] m);
    if (!wr)
    begin
      eq.push_back(d & m);
      mq.push_back(m);
    end
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wd <= d;
    // Only the bench timeout ends a wait for the answer.
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // One command strobe with its expected outcome.
  task automatic cmd(input logic [3:0] a, input logic e);
    cq.push_back(e);
    cs <= 1'b1;
    ca <= a;
    @(posedge clk);
    cs <= 1'b0;
    @(posedge clk);
  endtask

  // Takes the oldest note whenever a read answer or command slot shows.
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
      chk("read data", eq.pop_front(), rd & mq.pop_front());
    if (cs_q && cq.size() > 0)
      chk("command executed", {31'h0, cq.pop_front()}, {31'h0, exec});
    cs_q <= cs;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    {rst_n, cyc, stb, we, att, pf, cs, lp, la} = 9'h0;
    adr = 8'h0;
    wd = 32'h0;
    ca = 4'h0;
    xad = 4'h0;
    xa = 1'b0;
    gate = 1'b1; // Gate already high at power-up.
    w(10);
    rst_n <= 1'b1;
    w(3);
    wb(0, OFS_ADDR, 32'h1, 32'hF);
    wb(0, OFS_CTRL, 32'h0, 32'h4F);
    host.send(rnd(), DIV_LO, 1'b0);
    wb(0, OFS_STAT, 32'h0, 32'hFF);
    gate <= 1'b0;
    w(3);
    gate <= 1'b1;
    w(3);
    b = rnd();
    host.send(b, DIV_LO, 1'b0);
    wb(0, OFS_STAT, 32'h1, 32'hFF);
    wb(1, OFS_CTRL, 32'h4, 32'h0);
    gate <= 1'b0;
    host.send(rnd(), DIV_HI, 1'b0);
    gate <= 1'b1;
    w(3);
    b2 = rnd();
    host.send(b2, DIV_HI, 1'b0);
    wb(0, OFS_STAT, 32'h2, 32'hFF);
    wb(1, OFS_RIDX, 32'h0, 32'h0);
    wb(0, OFS_RDAT, {24'h0, b}, 32'h1FF);
    wb(1, OFS_RIDX, 32'h1, 32'h0);
    wb(0, OFS_RDAT, {24'h0, b2}, 32'h1FF);
    // Two connections in a row leave only one separator.
    att <= 1'b1;
    w(4);
    wb(0, OFS_STAT, 32'h403, 32'h4FF);
    att <= 1'b0;
    w(4);
    att <= 1'b1;
    w(4);
    wb(0, OFS_STAT, 32'h403, 32'h4FF);
    wb(1, OFS_RIDX, 32'h2, 32'h0);
    wb(0, OFS_RDAT, 32'h100, 32'h1FF);
    // Power loss drops what came since the last gate rise.
    gate <= 1'b0;
    w(3);
    gate <= 1'b1;
    w(3);
    host.send(rnd(), DIV_HI, 1'b0);
    wb(0, OFS_STAT, 32'h4, 32'hFF);
    pf <= 1'b1;
    w(4);
    wb(0, OFS_STAT, 32'h3, 32'hFF);
    pf <= 1'b0;
    host.send(rnd(), DIV_HI, 1'b1);
    wb(0, OFS_STAT, 32'h10200, 32'hFF0200);
    chk("accepting", 32'h0, {31'h0, acc});
    wb(1, OFS_CTRL, 32'h24, 32'h0);
    wb(0, OFS_STAT, 32'h0, 32'h200);
    chk("accepting", 32'h1, {31'h0, acc});
    wb(1, OFS_ADDR, 32'h3, 32'h0);
    wb(1, OFS_ADDR, 32'h9, 32'h0);
    wb(0, OFS_ADDR, 32'h3, 32'hF);
    lp <= 1'b1;
    la <= 1'b1;
    for (int a = 0; a < 10; a++)
      cmd(4'(a), a == 3);
    la <= 1'b0;
    lp <= 1'b0;
    cmd(4'h1, 1'b1);
    // Addressed method: address one waits for lower modules to fill.
    wb(1, OFS_CTRL, 32'h5, 32'h0);
    wb(1, OFS_CTRL, 32'h45, 32'h0);
    w(2);
    chk("dump request", 32'h1, {31'h0, dump});
    lp <= 1'b1;
    la <= 1'b1;
    xad <= ADDR_MIN;
    xa <= 1'b1;
    host.send(rnd(), DIV_HI, 1'b0);
    wb(0, OFS_STAT, 32'h3, 32'hFF);
    la <= 1'b0;
    b = rnd();
    host.send(b, DIV_HI, 1'b0);
    xa <= 1'b0;
    wb(0, OFS_STAT, 32'h4, 32'hFF);
    wb(1, OFS_RIDX, 32'h3, 32'h0);
    wb(0, OFS_RDAT, {24'h0, b}, 32'h1FF);
    wb(1, OFS_CTRL, 32'h40, 32'h0);
    w(2);
    chk("dump request", 32'h0, {31'h0, dump});
    w(3);
    chk("pending reads", 32'h0, eq.size());
    end_sim();
  end
endmodule

bind sds_core sds_core_properties chk_i (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .cmd_stb(cmd_stb), .cmd_addr(cmd_addr),
  .lower_accepting(lower_accepting), .present_o(present_o),
  .accepting_o(accepting_o), .cmd_exec_o(cmd_exec_o),
  .dump_req_o(dump_req_o));
